// [estop_defines.svh]
// Purpose: offsets, codes, reset values and bit positions of the emergency stop block
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   function codes are the drive's decimal codes written in hex
`ifndef ESTOP_DEFINES_SVH
`define ESTOP_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADDR_FUNC_LO      8'h00
`define ADDR_FUNC_HI      8'h04
`define ADDR_POL          8'h08
`define ADDR_STATUS       8'h0C
`define ADDR_IRQ_STAT     8'h10
`define ADDR_IRQ_MASK     8'h14
`define ADDR_PANEL_CMD    8'h18

// ----------------------------------------------------------------
// terminals and codes
// ----------------------------------------------------------------
`define NUM_TERMINALS     8
`define TERM_RESET_IDX    0
`define TERM_ESTOP_IDX    2
`define FUNC_RESET        8'h12
`define FUNC_JOG          8'h06
`define FUNC_ESTOP        8'h40
`define FUNC_NONE         8'hFF
`define POL_NO            1'b0
`define POL_NC            1'b1
`define TRIP_CODE_ESTOP   8'h25
`define TRIP_CODE_NONE    8'h00

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define IRQ_BITS          4
`define IRQ_TRIP          0
`define IRQ_SW_ON         1
`define IRQ_SW_OFF        2
`define IRQ_REFUSED       3
`define IRQ_MASK_RESET    4'h0

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_TRIP           0
`define ST_ENABLED        1
`define ST_RELEASED       2
`define ST_GATE_EN        3
`define ST_SWITCH         4
`define ST_CODE_LSB       8

`endif

// [estop_pkg.sv]
// Purpose: types shared by the emergency stop block
// Assumes: estop_defines.svh holds every number but the mode encodings
// Notes:   none
package estop_pkg;

  // ----------------------------------------------------------------
  // feature mode, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SHIPPED  = 3'b001,
    MODE_ENABLED  = 3'b010,
    MODE_RELEASED = 3'b100
  } mode_type;

  // ----------------------------------------------------------------
  // latched bus address phase
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
  } aphase_type;

endpackage : estop_pkg

// [sync2.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sync2
`default_nettype wire

// [trip_latch.sv]
// Purpose: emergency stop trip latch and output stage gate
// Assumes: inputs already synchronised
// Notes:   works from the raw contact level, not from software settings
`timescale 1ns/1ps
`default_nettype none
module trip_latch (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic estop_open,
  input  wire logic reset_req,
  output var  logic trip_reg,
  output var  logic gate_en_reg,
  output logic      trip_set
);

  logic trip_next;

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  always_comb begin
    trip_next = trip_reg;
    if (estop_open) begin
      trip_next = 1'b1;
    end else if (reset_req) begin
      trip_next = 1'b0;
    end
  end

  assign trip_set = estop_open & ~trip_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_reg    <= 1'b0;
      gate_en_reg <= 1'b0;
    end else begin
      trip_reg    <= trip_next;
      gate_en_reg <= ~trip_next & ~estop_open;
    end
  end

endmodule : trip_latch
`default_nettype wire

// [estop_cfg.sv]
// Purpose: emergency stop terminal configuration, trip logic and register slave
// Assumes: 40 MHz REF_CLK, AHB-Lite single word transfers, pins asynchronous
// Notes:   reads take one wait state, writes none
//
// What this block does
// - Feature is enabled only while the safety switch is on; off from shipment.
// - While enabled, terminals one and three are locked to the stop functions.
// - Terminal one is a normally-open reset; it resets drive and clears the trip.
// - Terminal three is a normally-closed stop; opening it cuts gates in hardware.
// - An open or miswired stop input trips; the outside must keep it closed.
// - While enabled, only the terminal one reset clears the trip; panel commands cannot.
// - Any terminal holding the reset function is forced to normally-open polarity.
// - Terminal three holding the stop function is forced to normally-closed polarity.
// - Switch turning on clears the reset function from every other terminal.
// - Switch turning off does not restore functions cleared at switch-on.
// - Software may never write the stop function to terminal three.
// - After on then off: terminal one keeps reset, three has none, all selectable.
// - Shipped defaults: terminal one reset, terminal three jog, both normally open.
`timescale 1ns/1ps
`default_nettype none
`include "estop_defines.svh"
module estop_cfg
  import estop_pkg::*;
(
  input  wire logic                      REF_CLK,
  input  wire logic                      RST_B,
  input  wire logic                      HSEL,
  input  wire logic [7:0]                HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output logic                           HREADYOUT,
  output logic                           HRESP,
  output var  logic [31:0]               HRDATA,
  input  wire logic                      SAFETY_ENABLE_SWITCH,
  input  wire logic [`NUM_TERMINALS-1:0] TERM_IN,
  output var  logic                      GATE_ENABLE,
  output var  logic                      DRIVE_RESET,
  output var  logic                      JOG_COMMAND,
  output var  logic [7:0]                TRIP_CODE,
  output var  logic                      IRQ
);

  localparam int NT = `NUM_TERMINALS;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NT:0]   pins_sync;
  logic [NT-1:0] term_sync;
  logic          sw_sync;
  logic          sw_prev_reg;
  logic          sw_rise;
  logic          sw_fall;

  sync2 #(.WIDTH(NT + 1)) u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({SAFETY_ENABLE_SWITCH, TERM_IN}),
    .q     (pins_sync)
  );

  assign term_sync = pins_sync[NT-1:0];
  assign sw_sync   = pins_sync[NT];
  assign sw_rise   = sw_sync & ~sw_prev_reg;
  assign sw_fall   = ~sw_sync & sw_prev_reg;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sw_prev_reg <= 1'b0;
    end else begin
      sw_prev_reg <= sw_sync;
    end
  end

  // ----------------------------------------------------------------
  // feature mode
  // ----------------------------------------------------------------
  mode_type mode_reg;
  mode_type mode_next;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_SHIPPED: begin
        if (sw_rise) mode_next = MODE_ENABLED;
      end
      MODE_ENABLED: begin
        if (sw_fall) mode_next = MODE_RELEASED;
      end
      MODE_RELEASED: begin
        if (sw_rise) mode_next = MODE_ENABLED;
      end
      default: mode_next = MODE_SHIPPED;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_reg <= MODE_SHIPPED;
    end else begin
      mode_reg <= mode_next;
    end
  end

  logic enabled;
  assign enabled = (mode_reg == MODE_ENABLED);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  aphase_type ap_reg;
  logic       rd_done_reg;
  logic       addr_take;
  logic       wr_commit;
  logic       rd_load;

  assign addr_take = HSEL & HTRANS[1] & HREADY;
  assign wr_commit = ap_reg.wr;
  assign rd_load   = ap_reg.rd & ~rd_done_reg;
  assign HREADYOUT = ~ap_reg.rd | rd_done_reg;
  assign HRESP     = 1'b0;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ap_reg      <= '0;
      rd_done_reg <= 1'b0;
    end else begin
      if (addr_take) begin
        ap_reg.addr <= HADDR;
        ap_reg.rd   <= ~HWRITE;
        ap_reg.wr   <= HWRITE;
      end else if (HREADYOUT) begin
        ap_reg.rd <= 1'b0;
        ap_reg.wr <= 1'b0;
      end
      rd_done_reg <= rd_load;
    end
  end

  // ----------------------------------------------------------------
  // terminal function and polarity selections
  // ----------------------------------------------------------------
  logic [7:0]    func_reg [NT];
  logic [7:0]    func_next[NT];
  logic [NT-1:0] pol_reg;
  logic [NT-1:0] pol_next;
  logic          refused;
  logic          wr_func;
  logic [7:0]    wbyte;

  always_comb begin
    refused = 1'b0;
    wbyte   = 8'h00;
    wr_func = 1'b0;
    pol_next = pol_reg;
    for (int i = 0; i < NT; i++) begin
      func_next[i] = func_reg[i];
    end
    if (sw_rise) begin
      for (int i = 0; i < NT; i++) begin
        if (func_reg[i] == `FUNC_RESET) func_next[i] = `FUNC_NONE;
      end
      func_next[`TERM_RESET_IDX] = `FUNC_RESET;
      func_next[`TERM_ESTOP_IDX] = `FUNC_ESTOP;
    end else if (sw_fall) begin
      func_next[`TERM_ESTOP_IDX] = `FUNC_NONE;
    end else if (wr_commit) begin
      for (int i = 0; i < NT; i++) begin
        wr_func = (ap_reg.addr == (i < 4 ? `ADDR_FUNC_LO : `ADDR_FUNC_HI));
        wbyte   = HWDATA[8*(i%4) +: 8];
        if (wr_func) begin
          if (enabled && (i == `TERM_RESET_IDX || i == `TERM_ESTOP_IDX)) begin
            refused = refused | (wbyte != func_reg[i]);
          end else if (wbyte == `FUNC_ESTOP) begin
            refused = 1'b1;
          end else begin
            func_next[i] = wbyte;
          end
        end
        if (ap_reg.addr == `ADDR_POL) begin
          if (enabled && (i == `TERM_RESET_IDX || i == `TERM_ESTOP_IDX)) begin
            refused = refused | (HWDATA[i] != pol_reg[i]);
          end else begin
            pol_next[i] = HWDATA[i];
          end
        end
      end
    end
    for (int i = 0; i < NT; i++) begin
      if (func_next[i] == `FUNC_RESET) pol_next[i] = `POL_NO;
    end
    if (func_next[`TERM_ESTOP_IDX] == `FUNC_ESTOP) begin
      pol_next[`TERM_ESTOP_IDX] = `POL_NC;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NT; i++) begin
        func_reg[i] <= `FUNC_NONE;
      end
      func_reg[`TERM_RESET_IDX] <= `FUNC_RESET;
      func_reg[`TERM_ESTOP_IDX] <= `FUNC_JOG;
      pol_reg <= '0;
    end else begin
      for (int i = 0; i < NT; i++) begin
        func_reg[i] <= func_next[i];
      end
      pol_reg <= pol_next;
    end
  end

  // ----------------------------------------------------------------
  // per-terminal decode
  // ----------------------------------------------------------------
  logic [NT-1:0] term_active;
  logic [NT-1:0] is_reset;
  logic [NT-1:0] is_jog;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_term
      assign term_active[g] = term_sync[g] ^ pol_reg[g];
      assign is_reset[g] = term_active[g] & (func_reg[g] == `FUNC_RESET) &
                           (~enabled | (g == `TERM_RESET_IDX));
      assign is_jog[g]   = term_active[g] & (func_reg[g] == `FUNC_JOG);
    end
  endgenerate

  // ----------------------------------------------------------------
  // trip and outputs
  // ----------------------------------------------------------------
  logic estop_open;
  logic reset_req;
  logic reset_prev_reg;
  logic trip;
  logic gate_en;
  logic trip_set;
  logic panel_reset;

  assign estop_open  = enabled & ~term_sync[`TERM_ESTOP_IDX];
  assign reset_req   = |is_reset;
  assign panel_reset = wr_commit & (ap_reg.addr == `ADDR_PANEL_CMD) & HWDATA[0];

  trip_latch u_trip (
    .clk         (REF_CLK),
    .rst_b       (RST_B),
    .estop_open  (estop_open),
    .reset_req   (reset_req),
    .trip_reg    (trip),
    .gate_en_reg (gate_en),
    .trip_set    (trip_set)
  );

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      reset_prev_reg <= 1'b0;
      DRIVE_RESET    <= 1'b0;
      JOG_COMMAND    <= 1'b0;
      GATE_ENABLE    <= 1'b0;
      TRIP_CODE      <= `TRIP_CODE_NONE;
    end else begin
      reset_prev_reg <= reset_req;
      DRIVE_RESET    <= (reset_req & ~reset_prev_reg) | panel_reset;
      JOG_COMMAND    <= |is_jog;
      GATE_ENABLE    <= gate_en;
      TRIP_CODE      <= trip ? `TRIP_CODE_ESTOP : `TRIP_CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`IRQ_BITS-1:0] irq_stat_reg;
  logic [`IRQ_BITS-1:0] irq_mask_reg;
  logic [`IRQ_BITS-1:0] irq_set;
  logic                 irq_clr;

  always_comb begin
    irq_set               = '0;
    irq_set[`IRQ_TRIP]    = trip_set;
    irq_set[`IRQ_SW_ON]   = sw_rise;
    irq_set[`IRQ_SW_OFF]  = sw_fall;
    irq_set[`IRQ_REFUSED] = refused;
  end

  assign irq_clr = rd_load & (ap_reg.addr == `ADDR_IRQ_STAT);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= `IRQ_MASK_RESET;
      IRQ          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_clr ? '0 : irq_stat_reg) | irq_set;
      if (wr_commit && ap_reg.addr == `ADDR_IRQ_MASK) begin
        irq_mask_reg <= HWDATA[`IRQ_BITS-1:0];
      end
      IRQ <= |(((irq_clr ? '0 : irq_stat_reg) | irq_set) & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (ap_reg.addr == `ADDR_FUNC_LO) begin
      rdata = {func_reg[3], func_reg[2], func_reg[1], func_reg[0]};
    end else if (ap_reg.addr == `ADDR_FUNC_HI) begin
      rdata = {func_reg[7], func_reg[6], func_reg[5], func_reg[4]};
    end else if (ap_reg.addr == `ADDR_POL) begin
      rdata[NT-1:0] = pol_reg;
    end else if (ap_reg.addr == `ADDR_STATUS) begin
      rdata[`ST_TRIP]                  = trip;
      rdata[`ST_ENABLED]               = enabled;
      rdata[`ST_RELEASED]              = (mode_reg == MODE_RELEASED);
      rdata[`ST_GATE_EN]               = gate_en;
      rdata[`ST_SWITCH]                = sw_sync;
      rdata[`ST_CODE_LSB +: 8]         = trip ? `TRIP_CODE_ESTOP : `TRIP_CODE_NONE;
    end else if (ap_reg.addr == `ADDR_IRQ_STAT) begin
      rdata[`IRQ_BITS-1:0] = irq_stat_reg;
    end else if (ap_reg.addr == `ADDR_IRQ_MASK) begin
      rdata[`IRQ_BITS-1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_load) begin
      HRDATA <= rdata;
    end
  end

endmodule : estop_cfg
`default_nettype wire

// [estop_cfg_asserts.sv]
// Purpose: port-level checks of the emergency stop block
// Assumes: one clock domain, RST_B active low
// Notes:   bound to every estop_cfg instance
`timescale 1ns/1ps
`default_nettype none
`include "estop_defines.svh"
module estop_cfg_asserts (
  input wire logic                      REF_CLK,
  input wire logic                      RST_B,
  input wire logic                      HSEL,
  input wire logic [1:0]                HTRANS,
  input wire logic                      HWRITE,
  input wire logic                      HREADY,
  input wire logic                      HREADYOUT,
  input wire logic                      HRESP,
  input wire logic                      SAFETY_ENABLE_SWITCH,
  input wire logic [`NUM_TERMINALS-1:0] TERM_IN,
  input wire logic                      GATE_ENABLE,
  input wire logic                      DRIVE_RESET,
  input wire logic [7:0]                TRIP_CODE
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_taken;    HSEL && HTRANS[1] && HREADY;             endsequence
  sequence s_sw_on;    SAFETY_ENABLE_SWITCH [*6];               endsequence
  sequence s_sw_off;   !SAFETY_ENABLE_SWITCH [*6];              endsequence
  sequence s_rst_idle; (TERM_IN[1:0] == 2'b00) [*5];            endsequence
  sequence s_clear;    (TERM_IN[0] && TERM_IN[2]) [*6];         endsequence

  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (s_taken ##0 !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (s_taken ##0 HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_trip_entry: assert property (
    s_sw_on ##0 !TERM_IN[2] |-> ##[1:5] (TRIP_CODE == 8'h25 && !GATE_ENABLE))
    else $error("open stop input did not trip");
  a_trip_gate: assert property (TRIP_CODE == 8'h25 |-> !GATE_ENABLE)
    else $error("gates on while tripped");
  a_trip_hold: assert property (
    s_rst_idle ##0 TRIP_CODE == 8'h25 |=> TRIP_CODE == 8'h25)
    else $error("trip cleared without reset input");
  a_trip_clear: assert property (s_clear |-> TRIP_CODE == 8'h00)
    else $error("reset input did not clear trip");
  a_no_trip_off: assert property (
    s_sw_off ##0 TRIP_CODE == 8'h00 |=> TRIP_CODE == 8'h00)
    else $error("trip while feature disabled");
  a_reset_pulse: assert property (DRIVE_RESET |=> !DRIVE_RESET)
    else $error("drive reset longer than one cycle");
  a_code_vals: assert property (TRIP_CODE == 8'h00 || TRIP_CODE == 8'h25)
    else $error("unexpected trip code");
endmodule : estop_cfg_asserts

bind estop_cfg estop_cfg_asserts estop_cfg_asserts_i (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SAFETY_ENABLE_SWITCH(SAFETY_ENABLE_SWITCH), .TERM_IN(TERM_IN),
  .GATE_ENABLE(GATE_ENABLE), .DRIVE_RESET(DRIVE_RESET), .TRIP_CODE(TRIP_CODE));
`default_nettype wire

// [estop_partner.sv]
// Purpose: external safety circuit driving the input terminals
// Assumes: commands from the bench change just after a rising edge
// Notes:   a cut wire floats, modelled as a level that flips every cycle
`timescale 1ns/1ps
`default_nettype none
module estop_partner (
  input  wire logic       clk,
  input  wire logic       open_cmd,
  input  wire logic       cut_cmd,
  input  wire logic       push_cmd,
  input  wire logic [7:0] aux,
  output var  logic [7:0] term_in
);
  always @(posedge clk) begin
    term_in[0]   <= push_cmd;
    term_in[1]   <= 1'b0;
    term_in[2]   <= cut_cmd ? ~term_in[2] : !open_cmd;
    term_in[7:3] <= aux[7:3];
  end
endmodule : estop_partner
`default_nettype wire

// [estop_cfg_test.sv]
// Purpose: self-checking bench of the emergency stop block
// Assumes: reads take one wait state, writes none
// Notes:   read results checked by a monitor from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
`include "estop_defines.svh"
module estop_cfg_test;
  logic        REF_CLK = 1'b0;
  logic        RST_B, HSEL, HWRITE, HREADYOUT, HRESP, SAFETY_ENABLE_SWITCH;
  logic        GATE_ENABLE, DRIVE_RESET, JOG_COMMAND, IRQ;
  logic        open_cmd, cut_cmd, push_cmd, hr_s, g_s, j_s, i_s, rd_pend;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [7:0]  HADDR, TRIP_CODE, TERM_IN, aux, t_s;
  logic [31:0] HWDATA, HRDATA, rd_s, r;
  logic [31:0] exp_q[$];
  int          errors, checks, pulses, p;

  always #12.5 REF_CLK = ~REF_CLK;

  estop_cfg estop_cfg_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .SAFETY_ENABLE_SWITCH(SAFETY_ENABLE_SWITCH), .TERM_IN(TERM_IN),
    .GATE_ENABLE(GATE_ENABLE), .DRIVE_RESET(DRIVE_RESET), .JOG_COMMAND(JOG_COMMAND),
    .TRIP_CODE(TRIP_CODE), .IRQ(IRQ));
  estop_partner estop_partner_i (.clk(REF_CLK), .open_cmd(open_cmd), .cut_cmd(cut_cmd),
    .push_cmd(push_cmd), .aux(aux), .term_in(TERM_IN));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t pin got %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge REF_CLK);
      aux <= 8'($urandom) & 8'hF8;
    end
  endtask : tick

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= a;
    HWRITE <= w;
    do @(posedge REF_CLK); while (hr_s !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge REF_CLK); while (hr_s !== 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  always @(negedge REF_CLK) begin
    hr_s <= HREADYOUT;
    rd_s <= HRDATA;
    g_s  <= GATE_ENABLE;
    j_s  <= JOG_COMMAND;
    i_s  <= IRQ;
    t_s  <= TRIP_CODE;
    if (DRIVE_RESET === 1'b1) pulses <= pulses + 1;
  end

  always @(posedge REF_CLK) begin
    if (rd_pend && hr_s) cmp(rd_s, exp_q.pop_front());
    if (hr_s) rd_pend <= HSEL && HTRANS[1] && !HWRITE;
  end

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {RST_B, HSEL, HWRITE, SAFETY_ENABLE_SWITCH, open_cmd, cut_cmd, push_cmd} = 7'h00;
    {HTRANS, HADDR, HWDATA, aux} = '0;
    HSIZE = 3'h2;
    void'($urandom(67));
    repeat (4) @(posedge REF_CLK);
    RST_B <= 1'b1;
    tick(3);
    rd(`ADDR_FUNC_LO, 32'hFF06FF12);
    rd(`ADDR_POL, 32'h0);
    tick(2);
    cmp_pin({31'h0, j_s}, 32'h1);
    open_cmd <= 1'b1;
    tick(8);
    cmp_pin({24'h0, t_s}, 32'h0);
    cmp_pin({31'h0, j_s}, 32'h0);
    open_cmd <= 1'b0;
    wr(`ADDR_FUNC_LO, 32'hFF061212);
    wr(`ADDR_POL, 32'h2);
    rd(`ADDR_POL, 32'h0);
    wr(`ADDR_FUNC_LO, 32'hFF401212);
    rd(`ADDR_FUNC_LO, 32'hFF061212);
    tick(3);
    cmp_pin({31'h0, i_s}, 32'h0);
    wr(`ADDR_IRQ_MASK, 32'h8);
    tick(3);
    cmp_pin({31'h0, i_s}, 32'h1);
    rd(`ADDR_IRQ_STAT, 32'h8);
    tick(3);
    cmp_pin({31'h0, i_s}, 32'h0);
    SAFETY_ENABLE_SWITCH <= 1'b1;
    tick(6);
    rd(`ADDR_FUNC_LO, 32'hFF40FF12);
    rd(`ADDR_POL, 32'h4);
    wr(`ADDR_FUNC_LO, 32'hFF06FF06);
    rd(`ADDR_FUNC_LO, 32'hFF40FF12);
    for (int k = 0; k < 4; k++) r[8*k +: 8] = $urandom_range(1) ? 8'h06 : 8'hFF;
    wr(`ADDR_FUNC_HI, r);
    rd(`ADDR_FUNC_HI, r);
    rd(`ADDR_IRQ_STAT, 32'hA);
    for (int f = 0; f < 2; f++) begin
      if (f == 0) open_cmd <= 1'b1;
      else cut_cmd <= 1'b1;
      tick(6);
      cmp_pin({24'h0, t_s}, 32'h25);
      cmp_pin({31'h0, g_s}, 32'h0);
      rd(`ADDR_STATUS, 32'h2513);
      open_cmd <= 1'b0;
      cut_cmd  <= 1'b0;
      tick(6);
      cmp_pin({24'h0, t_s}, 32'h25);
      wr(`ADDR_PANEL_CMD, 32'h1);
      tick(6);
      cmp_pin({24'h0, t_s}, 32'h25);
      p = pulses;
      push_cmd <= 1'b1;
      tick(8);
      push_cmd <= 1'b0;
      tick(2);
      cmp_pin({24'h0, t_s}, 32'h0);
      cmp_pin({31'h0, g_s}, 32'h1);
      cmp_pin(32'(pulses), 32'(p + 1));
    end
    rd(`ADDR_IRQ_STAT, 32'h1);
    SAFETY_ENABLE_SWITCH <= 1'b0;
    tick(6);
    rd(`ADDR_FUNC_LO, 32'hFFFFFF12);
    rd(`ADDR_POL, 32'h4);
    rd(`ADDR_IRQ_STAT, 32'h4);
    rd(`ADDR_STATUS, 32'hC);
    wr(`ADDR_FUNC_LO, 32'hFF06FF12);
    rd(`ADDR_FUNC_LO, 32'hFF06FF12);
    open_cmd <= 1'b1;
    tick(8);
    cmp_pin({24'h0, t_s}, 32'h0);
    end_of_test();
  end
endmodule : estop_cfg_test
`default_nettype wire
